// >>> logic/usfd_ctrl.v
/*
 * Shadow FIFO-control registers of the second serial port: field-wise
 * access to the DMA mode, FIFO enable and receive trigger, FIFO level
 * tracking, DMA requests and the interrupt status/mask pair.
 * Assumes a register master that never issues read and write together,
 * and push/pop strobes synchronous to CLK_I.
 */
//
// Behaviour
// R1: DMA-mode shadow writes change only the DMA-mode field of the control word.
// R2: DMA mode 0 or 1 picks the signalling scheme of both DMA requests.
// R3: FIFO-enable shadow writes change only the FIFO-enable field.
// R4: Enable one runs both FIFOs; enable zero bypasses them to one entry.
// R5: Enable falling from one to zero empties both FIFO controls.
// R6: Receive-trigger shadow writes change only the two trigger bits.
// R7: Trigger picks data-available level: one, quarter, half, two below full.
// R8: In DMA mode 1 the receive request follows the same trigger level.
// R9: All three fields reset to zero; upper shadow bits read as zero.
// R10: Shadow reads return the live field, whichever path wrote it last.
`include "usfd_regs.vh"

module usfd_ctrl (
    // clock and reset
    input wire CLK_I,
    input wire RESETN_I,
    // register port
    input wire [31:0] ADDR_I,
    input wire [15:0] WDATA_I,
    input wire WE_I,
    input wire RE_I,
    output wire [15:0] RDATA_O,
    // receive and transmit traffic
    input wire RX_PUSH_I,
    input wire RX_POP_I,
    input wire TX_PUSH_I,
    input wire TX_POP_I,
    // DMA requests, active low
    output wire DMA_TX_REQ_N_O,
    output wire DMA_RX_REQ_N_O,
    // status
    output wire FIFO_EN_O,
    output wire RX_AVAIL_O,
    output wire RX_FULL_O,
    output wire TX_FULL_O,
    // interrupt
    output wire INTR_O
);

////////////////////////////////////////////////////////////////////////////////
// decoding helpers

// fill level that counts as "data available" for a trigger setting
function [4:0] usfd_thresh;
    input [1:0] trig;
    input en;
    begin
        if (!en) begin
            usfd_thresh = `USFD_LVL_ONE;
        end else begin
            case (trig)
                `USFD_TRIG_ONE: usfd_thresh = `USFD_LVL_ONE;
                `USFD_TRIG_QUARTER: usfd_thresh = `USFD_LVL_QUARTER;
                `USFD_TRIG_HALF: usfd_thresh = `USFD_LVL_HALF;
                `USFD_TRIG_NEAR_FULL: usfd_thresh = `USFD_LVL_NEAR_FULL;
                default: usfd_thresh = `USFD_LVL_ONE;
            endcase
        end
    end
endfunction

// one address match, used for both the write and the read paths
function hit;
    input [31:0] addr;
    input [31:0] target;
    begin
        hit = (addr == target);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// control word fields

reg dma_mode_ff;
reg fifo_en_ff;
reg [1:0] rx_trig_ff;
reg nxt_dma_mode;
reg nxt_fifo_en;
reg [1:0] nxt_rx_trig;

wire wr_dma_mode = WE_I & hit(ADDR_I, `USFD_ADDR_SHADOW_DMA_MODE);
wire wr_fifo_en = WE_I & hit(ADDR_I, `USFD_ADDR_SHADOW_FIFO_EN);
wire wr_rx_trig = WE_I & hit(ADDR_I, `USFD_ADDR_SHADOW_RX_TRIG);
wire wr_ctrl = WE_I & hit(ADDR_I, `USFD_ADDR_CTRL_WORD);
wire wr_status = WE_I & hit(ADDR_I, `USFD_ADDR_IRQ_STATUS);
wire wr_mask = WE_I & hit(ADDR_I, `USFD_ADDR_IRQ_MASK);

// each shadow touches one field; the full word writes all three at once
always @* begin
    nxt_dma_mode = dma_mode_ff;
    nxt_fifo_en = fifo_en_ff;
    nxt_rx_trig = rx_trig_ff;
    if (wr_ctrl) begin
        nxt_dma_mode = WDATA_I[`USFD_CW_DMA_MODE_BIT]; // R10
        nxt_fifo_en = WDATA_I[`USFD_CW_FIFO_EN_BIT]; // R10
        nxt_rx_trig = WDATA_I[`USFD_CW_RX_TRIG_MSB:`USFD_CW_RX_TRIG_LSB]; // R10
    end
    if (wr_dma_mode) begin
        nxt_dma_mode = WDATA_I[0]; // R1
    end
    if (wr_fifo_en) begin
        nxt_fifo_en = WDATA_I[0]; // R3
    end
    if (wr_rx_trig) begin
        nxt_rx_trig = WDATA_I[1:0]; // R6
    end
end

always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
        dma_mode_ff <= `USFD_RST_DMA_MODE; // R9
        fifo_en_ff <= `USFD_RST_FIFO_EN; // R9
        rx_trig_ff <= `USFD_RST_RX_TRIG; // R9
    end else begin
        dma_mode_ff <= nxt_dma_mode;
        fifo_en_ff <= nxt_fifo_en;
        rx_trig_ff <= nxt_rx_trig;
    end
end

////////////////////////////////////////////////////////////////////////////////
// FIFO control portions

// flush on the very edge where the enable drops, so no stale data survives
wire fifo_flush = fifo_en_ff & ~nxt_fifo_en; // R5
// bypass leaves a single holding entry on each side
wire [4:0] fifo_cap = fifo_en_ff ? `USFD_DEPTH : `USFD_LVL_ONE; // R4
wire [4:0] rx_count;
wire [4:0] tx_count;
wire rx_full;
wire rx_empty;
wire tx_full;
wire tx_empty;

usfd_level u_rx_level (
    .clk_i(CLK_I),
    .rst_n_i(RESETN_I),
    .clr_i(fifo_flush),
    .cap_i(fifo_cap),
    .push_i(RX_PUSH_I),
    .pop_i(RX_POP_I),
    .count_o(rx_count),
    .full_o(rx_full),
    .empty_o(rx_empty)
);

usfd_level u_tx_level (
    .clk_i(CLK_I),
    .rst_n_i(RESETN_I),
    .clr_i(fifo_flush),
    .cap_i(fifo_cap),
    .push_i(TX_PUSH_I),
    .pop_i(TX_POP_I),
    .count_o(tx_count),
    .full_o(tx_full),
    .empty_o(tx_empty)
);

////////////////////////////////////////////////////////////////////////////////
// receive threshold and DMA requests

wire [4:0] rx_thr = usfd_thresh(rx_trig_ff, fifo_en_ff); // R7
wire rx_avail = (rx_count >= rx_thr); // R7

usfd_dma u_dma (
    .clk_i(CLK_I),
    .rst_n_i(RESETN_I),
    .mode_i(dma_mode_ff),
    .rx_thr_i(rx_thr),
    .rx_count_i(rx_count),
    .rx_empty_i(rx_empty),
    .tx_empty_i(tx_empty),
    .tx_full_i(tx_full),
    .tx_req_n_o(DMA_TX_REQ_N_O),
    .rx_req_n_o(DMA_RX_REQ_N_O)
);

////////////////////////////////////////////////////////////////////////////////
// interrupt status and mask

reg rx_avail_ff;
reg tx_empty_d_ff;
reg [2:0] irq_status_ff;
reg [2:0] irq_mask_ff;
reg [2:0] nxt_irq_status;
reg [2:0] nxt_irq_mask;
wire [2:0] irq_event;

// edges, so a level that stays up raises the flag only once
assign irq_event[`USFD_IRQ_RX_AVAIL_BIT] = rx_avail & ~rx_avail_ff;
assign irq_event[`USFD_IRQ_TX_EMPTY_BIT] = tx_empty & ~tx_empty_d_ff;
assign irq_event[`USFD_IRQ_FIFO_FLUSH_BIT] = fifo_flush;

// write-one-to-clear; an event in the clearing cycle wins
always @* begin
    nxt_irq_status = irq_status_ff;
    nxt_irq_mask = irq_mask_ff;
    if (wr_status) begin
        nxt_irq_status = irq_status_ff & ~WDATA_I[2:0];
    end
    nxt_irq_status = nxt_irq_status | irq_event;
    if (wr_mask) begin
        nxt_irq_mask = WDATA_I[2:0];
    end
end

always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
        rx_avail_ff <= 1'b0;
        tx_empty_d_ff <= 1'b1;
        irq_status_ff <= `USFD_RST_IRQ;
        irq_mask_ff <= `USFD_RST_IRQ;
    end else begin
        rx_avail_ff <= rx_avail;
        tx_empty_d_ff <= tx_empty;
        irq_status_ff <= nxt_irq_status;
        irq_mask_ff <= nxt_irq_mask;
    end
end

assign INTR_O = |(irq_status_ff & irq_mask_ff);

////////////////////////////////////////////////////////////////////////////////
// read path

reg [15:0] rdata_ff;
reg [15:0] nxt_rdata;

// data stand only in the cycle after the strobe; unmapped reads give zero
always @* begin
    nxt_rdata = 16'h0000;
    if (RE_I) begin
        if (hit(ADDR_I, `USFD_ADDR_SHADOW_DMA_MODE)) begin
            nxt_rdata = {15'h0000, dma_mode_ff}; // R10
        end else if (hit(ADDR_I, `USFD_ADDR_SHADOW_FIFO_EN)) begin
            nxt_rdata = {15'h0000, fifo_en_ff}; // R10
        end else if (hit(ADDR_I, `USFD_ADDR_SHADOW_RX_TRIG)) begin
            nxt_rdata = {14'h0000, rx_trig_ff}; // R9
        end else if (hit(ADDR_I, `USFD_ADDR_CTRL_WORD)) begin
            nxt_rdata = {8'h00, rx_trig_ff, 2'h0, dma_mode_ff, 2'h0, fifo_en_ff};
        end else if (hit(ADDR_I, `USFD_ADDR_IRQ_STATUS)) begin
            nxt_rdata = {13'h0000, irq_status_ff};
        end else if (hit(ADDR_I, `USFD_ADDR_IRQ_MASK)) begin
            nxt_rdata = {13'h0000, irq_mask_ff};
        end else if (hit(ADDR_I, `USFD_ADDR_FIFO_LEVEL)) begin
            nxt_rdata = {3'h0, tx_count, 3'h0, rx_count};
        end
    end
end

always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
        rdata_ff <= 16'h0000;
    end else begin
        rdata_ff <= nxt_rdata;
    end
end

assign RDATA_O = rdata_ff;

////////////////////////////////////////////////////////////////////////////////
// status outputs

reg rx_full_ff;
reg tx_full_ff;

// registered copies keep the full-flag outputs glitch free
always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
        rx_full_ff <= 1'b0;
        tx_full_ff <= 1'b0;
    end else begin
        rx_full_ff <= rx_full;
        tx_full_ff <= tx_full;
    end
end

assign FIFO_EN_O = fifo_en_ff; // R4
assign RX_AVAIL_O = rx_avail_ff;
assign RX_FULL_O = rx_full_ff;
assign TX_FULL_O = tx_full_ff;

endmodule

// >>> logic/usfd_regs.vh
/*
 * Register map, field positions, reset values and sizes of the shadow
 * FIFO-control block. Assumes a plain address/strobe register port.
 */
`ifndef USFD_REGS_VH
`define USFD_REGS_VH

// shadow register byte addresses
`define USFD_ADDR_SHADOW_DMA_MODE 32'h50001194
`define USFD_ADDR_SHADOW_FIFO_EN 32'h50001198
`define USFD_ADDR_SHADOW_RX_TRIG 32'h5000119C
// full control word, interrupt and level registers
`define USFD_ADDR_CTRL_WORD 32'h50001108
`define USFD_ADDR_IRQ_STATUS 32'h500011C0
`define USFD_ADDR_IRQ_MASK 32'h500011C4
`define USFD_ADDR_FIFO_LEVEL 32'h500011C8

// field positions inside the full control word
`define USFD_CW_FIFO_EN_BIT 0
`define USFD_CW_DMA_MODE_BIT 3
`define USFD_CW_RX_TRIG_LSB 6
`define USFD_CW_RX_TRIG_MSB 7

// interrupt status bit positions
`define USFD_IRQ_RX_AVAIL_BIT 0
`define USFD_IRQ_TX_EMPTY_BIT 1
`define USFD_IRQ_FIFO_FLUSH_BIT 2
`define USFD_IRQ_WIDTH 3

// reset values
`define USFD_RST_DMA_MODE 1'h0
`define USFD_RST_FIFO_EN 1'h0
`define USFD_RST_RX_TRIG 2'h0
`define USFD_RST_IRQ 3'h0

// receive trigger encodings
`define USFD_TRIG_ONE 2'h0
`define USFD_TRIG_QUARTER 2'h1
`define USFD_TRIG_HALF 2'h2
`define USFD_TRIG_NEAR_FULL 2'h3

// FIFO depth and the fill levels that follow from it
`define USFD_DEPTH 5'h10
`define USFD_LVL_ONE 5'h01
`define USFD_LVL_QUARTER 5'h04
`define USFD_LVL_HALF 5'h08
`define USFD_LVL_NEAR_FULL 5'h0E

`endif

// >>> logic/usfd_level.v
/*
 * Fill-level tracker standing for the control portion of one FIFO.
 * Assumes push and pop are one-cycle strobes synchronous to clk_i.
 */
module usfd_level (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // control
    input wire clr_i,
    input wire [4:0] cap_i,
    // traffic
    input wire push_i,
    input wire pop_i,
    // state
    output wire [4:0] count_o,
    output wire full_o,
    output wire empty_o
);

reg [4:0] count_ff;
reg [4:0] nxt_count;
wire do_push;
wire do_pop;

// push into a full FIFO and pop from an empty one are dropped
assign do_push = push_i & (count_ff < cap_i);
assign do_pop = pop_i & (count_ff != 5'h00);
assign count_o = count_ff;
assign full_o = (count_ff >= cap_i);
assign empty_o = (count_ff == 5'h00);

// clear beats traffic so the FIFO really reads empty afterwards
always @* begin
    nxt_count = count_ff;
    if (clr_i) begin
        nxt_count = 5'h00;
    end else if (do_push & ~do_pop) begin
        nxt_count = count_ff + 5'h01;
    end else if (do_pop & ~do_push) begin
        nxt_count = count_ff - 5'h01;
    end
end

always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        count_ff <= 5'h00;
    end else begin
        count_ff <= nxt_count;
    end
end

endmodule

// >>> logic/usfd_dma.v
/*
 * DMA request generator for the transmit and receive sides.
 * Assumes the fill levels and threshold come from the same clock domain.
 */
module usfd_dma (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // configuration
    input wire mode_i,
    input wire [4:0] rx_thr_i,
    // fill state
    input wire [4:0] rx_count_i,
    input wire rx_empty_i,
    input wire tx_empty_i,
    input wire tx_full_i,
    // requests, active low
    output wire tx_req_n_o,
    output wire rx_req_n_o
);

reg tx_req_ff;
reg rx_req_ff;
reg nxt_tx_req;
reg nxt_rx_req;

assign tx_req_n_o = ~tx_req_ff;
assign rx_req_n_o = ~rx_req_ff;

// mode 0 follows single characters, mode 1 works in bursts with hysteresis
always @* begin
    nxt_tx_req = tx_req_ff;
    nxt_rx_req = rx_req_ff;
    if (!mode_i) begin
        nxt_tx_req = tx_empty_i; // R2
        nxt_rx_req = ~rx_empty_i; // R2
    end else begin
        // receive burst held until the FIFO is drained, transmit burst until it is full, so no request chatter
        if (rx_count_i >= rx_thr_i) begin
            nxt_rx_req = 1'b1; // R8
        end else if (rx_empty_i) begin
            nxt_rx_req = 1'b0; // R8
        end
        if (tx_empty_i) begin
            nxt_tx_req = 1'b1; // R2
        end else if (tx_full_i) begin
            nxt_tx_req = 1'b0; // R2
        end
    end
end

always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        tx_req_ff <= 1'b0;
        rx_req_ff <= 1'b0;
    end else begin
        tx_req_ff <= nxt_tx_req;
        rx_req_ff <= nxt_rx_req;
    end
end

endmodule

// >>> tb/usfd_ctrl_asserts.sv
/*
 * Port-level checks of the shadow FIFO-control block.
 * Assumes it is bound to usfd_ctrl and sees only that module's ports.
 */
`include "usfd_regs.vh"

module usfd_ctrl_asserts (
    // clock and reset
    input wire CLK_I,
    input wire RESETN_I,
    // register port
    input wire [31:0] ADDR_I,
    input wire [15:0] WDATA_I,
    input wire WE_I,
    input wire RE_I,
    input wire [15:0] RDATA_O,
    // status
    input wire FIFO_EN_O,
    input wire RX_AVAIL_O,
    input wire RX_FULL_O,
    input wire TX_FULL_O
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////
    // decoded accesses
    wire wr_dm = WE_I && ADDR_I == `USFD_ADDR_SHADOW_DMA_MODE;
    wire wr_fe = WE_I && ADDR_I == `USFD_ADDR_SHADOW_FIFO_EN;
    wire wr_rt = WE_I && ADDR_I == `USFD_ADDR_SHADOW_RX_TRIG;
    wire wr_cw = WE_I && ADDR_I == `USFD_ADDR_CTRL_WORD;
    wire rd_fe = RE_I && ADDR_I == `USFD_ADDR_SHADOW_FIFO_EN;
    wire rd_rt = RE_I && ADDR_I == `USFD_ADDR_SHADOW_RX_TRIG;
    wire rd_dm = RE_I && ADDR_I == `USFD_ADDR_SHADOW_DMA_MODE;

    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);

    ////////////////////////////////////////
    // read port and field isolation
    rd_idle_a: assert property (!$past(RE_I) |-> RDATA_O == 16'h0)
        else $error("read data outside its slot");
    fe_write_a: assert property (wr_fe |=> FIFO_EN_O == $past(WDATA_I[0]))
        else $error("enable shadow write lost");
    dma_keeps_en_a: assert property (wr_dm |=> $stable(FIFO_EN_O))
        else $error("mode write moved enable");
    trig_keeps_en_a: assert property (wr_rt |=> $stable(FIFO_EN_O))
        else $error("trigger write moved enable");
    word_en_a: assert property (wr_cw |=> FIFO_EN_O == $past(WDATA_I[0]))
        else $error("word write lost enable");
    trig_rb_a: assert property (wr_rt ##1 rd_rt |=> RDATA_O == {14'h0, $past(WDATA_I[1:0], 2)})
        else $error("trigger readback wrong");
    word_rb_a: assert property (wr_cw ##1 rd_fe |=> RDATA_O == {15'h0, $past(WDATA_I[0], 2)})
        else $error("enable not seen via word");
    resv_zero_a: assert property (rd_dm || rd_fe |=> RDATA_O[15:1] == 15'h0)
        else $error("reserved bits set");

    ////////////////////////////////////////
    // fifo control: flush empties, bypass holds one entry
    flush_clear_a: assert property ($fell(FIFO_EN_O) |=> !RX_AVAIL_O && !RX_FULL_O && !TX_FULL_O)
        else $error("flush left data");
    bypass_cap_a: assert property (!FIFO_EN_O && $stable(FIFO_EN_O) |-> RX_AVAIL_O == RX_FULL_O)
        else $error("bypass depth not one");

    // main scenarios reached
    cover property (wr_cw ##1 rd_fe);
    cover property ($fell(FIFO_EN_O));
    cover property ($rose(RX_AVAIL_O));
endmodule

bind usfd_ctrl usfd_ctrl_asserts u_chk (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WE_I(WE_I), .RE_I(RE_I), .RDATA_O(RDATA_O), .FIFO_EN_O(FIFO_EN_O),
    .RX_AVAIL_O(RX_AVAIL_O), .RX_FULL_O(RX_FULL_O), .TX_FULL_O(TX_FULL_O));

// >>> tb/usfd_dma_peer.sv
/*
 * DMA controller stand-in: answers both request lines with strobes.
 * Assumes the block's clock and reset.
 */
module usfd_dma_peer (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // control and requests
    input wire logic serve_i,
    input wire logic rx_req_n_i,
    input wire logic tx_req_n_i,
    // strobes toward the block
    output logic rx_pop_o,
    output logic tx_push_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] gap;
    logic go;

    assign go = serve_i && gap == 2'h0;
    // two idle edges after a strobe, as the request lags the count
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gap <= 2'h0;
            rx_pop_o <= 1'b0;
            tx_push_o <= 1'b0;
        end else begin
            rx_pop_o <= go && !rx_req_n_i;
            tx_push_o <= go && !tx_req_n_i;
            gap <= go ? 2'h2 : (gap == 2'h0 ? 2'h0 : gap - 2'h1);
        end
    end
endmodule

// >>> tb/test_usfd_ctrl.sv
/*
 * Self-checking bench of the shadow FIFO-control block.
 * Assumes the DMA stand-in and the bound checker are compiled first.
 */
`include "usfd_regs.vh"

module test_usfd_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] DM = `USFD_ADDR_SHADOW_DMA_MODE;
    localparam logic [31:0] FE = `USFD_ADDR_SHADOW_FIFO_EN;
    localparam logic [31:0] RT = `USFD_ADDR_SHADOW_RX_TRIG;
    localparam logic [31:0] CW = `USFD_ADDR_CTRL_WORD;
    localparam logic [31:0] ST = `USFD_ADDR_IRQ_STATUS;
    localparam logic [31:0] MK = `USFD_ADDR_IRQ_MASK;
    localparam logic [31:0] LV = `USFD_ADDR_FIFO_LEVEL;
    logic clk = 0, rst_n = 0, we = 0, re = 0, rx_push = 0, tx_pop = 0, serve = 0;
    logic [31:0] addr = 0;
    logic [15:0] wdata = 0, rd_v;
    wire [15:0] rdata;
    wire rx_pop, tx_push, tx_req_n, rx_req_n, fifo_en, rx_avail, rx_full, tx_full, intr;
    int num_errors = 0, comparisons = 0;

    always #5 clk = ~clk;

    usfd_ctrl u_dut (.CLK_I(clk), .RESETN_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WE_I(we),
        .RE_I(re), .RDATA_O(rdata), .RX_PUSH_I(rx_push), .RX_POP_I(rx_pop), .TX_PUSH_I(tx_push),
        .TX_POP_I(tx_pop), .DMA_TX_REQ_N_O(tx_req_n), .DMA_RX_REQ_N_O(rx_req_n),
        .FIFO_EN_O(fifo_en), .RX_AVAIL_O(rx_avail), .RX_FULL_O(rx_full), .TX_FULL_O(tx_full),
        .INTR_O(intr));
    usfd_dma_peer u_peer (.clk_i(clk), .rst_n_i(rst_n), .serve_i(serve), .rx_req_n_i(rx_req_n),
        .tx_req_n_i(tx_req_n), .rx_pop_o(rx_pop), .tx_push_o(tx_push));

    ////////////////////////////////////////
    // bus cycles and comparison
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge clk);
        we <= 1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        we <= 0;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // write then read with no gap, so readback sees the write at once
    task automatic wrrd(input string n, input logic [31:0] wa, input logic [15:0] wd,
                        input logic [31:0] ra, input logic [15:0] e);
        @(posedge clk);
        we <= 1;
        addr <= wa;
        wdata <= wd;
        @(posedge clk);
        we <= 0;
        re <= 1;
        addr <= ra;
        @(posedge clk);
        re <= 0;
        #1 chk(n, e, rdata);
    endtask
    // data stands only in the cycle after the strobe
    task automatic rchk(input string n, input logic [31:0] a, input logic [15:0] e);
        @(posedge clk);
        re <= 1;
        addr <= a;
        @(posedge clk);
        re <= 0;
        #1 chk(n, e, rdata);
    endtask
    // outputs lag the count by one edge, so wait two
    task automatic push(input int n);
        repeat (n) begin
            @(posedge clk);
            rx_push <= 1;
            @(posedge clk);
            rx_push <= 0;
        end
        repeat (2) @(posedge clk);
        #1;
    endtask

    ////////////////////////////////////////
    // scenarios
    task automatic t_regs;
        rchk("mode rst", DM, 0);
        rchk("en rst", FE, 0);
        rchk("trig rst", RT, 0);
        wr(DM, 16'hFFFF);
        wr(FE, 16'hFFFF);
        wr(RT, 16'hFFFF);
        rchk("trig", RT, 16'h0003);
        rchk("mode", DM, 16'h0001);
        rchk("en", FE, 16'h0001);
        rchk("word", CW, 16'h00C9);
        wrrd("en via word", CW, 16'h0048, FE, 0);
        rchk("mode via word", DM, 1);
        rchk("trig via word", RT, 1);
        wrrd("trig b2b", RT, 16'h0002, RT, 16'h0002);
        rchk("word kept", CW, 16'h0088);
        rchk("unmapped", 32'h50001190, 0);
    endtask
    task automatic t_trig;
        int lv[4] = '{1, 4, 8, 14};
        for (int t = 0; t < 4; t++) begin
            wr(CW, 16'h0000);
            wr(CW, {8'h0, t[1:0], 6'h01});
            push(lv[t] - 1);
            chk("below level", 0, rx_avail);
            push(1);
            chk("at level", 1, rx_avail);
        end
        chk("rx req mode 0", 0, rx_req_n);
        chk("tx req mode 0", 0, tx_req_n);
        wr(FE, 0);
        repeat (2) @(posedge clk);
        #1 chk("flushed avail", 0, rx_avail);
        rchk("flushed level", LV, 0);
    endtask
    task automatic t_bypass;
        push(1);
        chk("bypass full", 1, rx_full);
        push(1);
        rchk("bypass level", LV, 16'h0001);
        wr(FE, 1);
        push(1);
        chk("fifo on not full", 0, rx_full);
        chk("en out", 1, fifo_en);
    endtask
    // mode 1: request waits for trigger level, then holds until drained
    task automatic t_dma;
        wr(CW, 16'h0000);
        wr(CW, 16'h0049);
        push(3);
        chk("rx req below", 1, rx_req_n);
        chk("tx req mode 1", 0, tx_req_n);
        push(1);
        chk("rx req at level", 0, rx_req_n);
        @(posedge clk) serve <= 1;
        // look off the edge so the registered flag has settled
        for (int i = 0; i < 200 && tx_full !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        repeat (3) @(posedge clk);
        serve <= 0;
        #1 chk("rx req drained", 1, rx_req_n);
        chk("tx req at full", 1, tx_req_n);
        chk("tx full", 1, tx_full);
        rchk("levels", LV, 16'h1000);
    endtask
    task automatic t_irq;
        wr(MK, 16'h0001);
        wr(ST, 16'h0007);
        wr(RT, 0);
        push(1);
        @(posedge clk);
        #1 chk("irq raised", 1, intr);
        wr(ST, 16'h0001);
        #1 chk("irq cleared", 0, intr);
        wr(MK, 16'h0004);
        wr(FE, 0);
        #1 chk("flush irq", 1, intr);
        wr(MK, 0);
        #1 chk("irq masked", 0, intr);
        wr(MK, 16'h0002);
        #1 chk("tx empty irq", 1, intr);
        rchk("status", ST, 16'h0006);
    endtask
    // mid-run reset puts every field back to zero
    task automatic t_reset;
        wr(CW, 16'h00C9);
        @(posedge clk) rst_n <= 0;
        repeat (2) @(posedge clk);
        rst_n <= 1;
        #1 chk("en out rerst", 0, fifo_en);
        rchk("mode rerst", DM, 0);
        rchk("en rerst", FE, 0);
        rchk("trig rerst", RT, 0);
    endtask

    ////////////////////////////////////////
    // verdict, main sequence, watchdog
    task automatic wrap_up;
        if (num_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1;
        t_regs;
        t_trig;
        t_bypass;
        t_dma;
        t_irq;
        t_reset;
        wrap_up;
    end
    // a hung handshake ends the run as a failure
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        wrap_up;
    end
endmodule
